// file: rtl/ucp_link_if.sv
// Pin bundle between master and slave cell port
`timescale 1ns/10ps
interface ucp_link_if;
  logic             tx_link_clock;
  logic             rx_link_clock;
  ucp_pkg::ucp_byte_t tx_cell_byte;
  logic             tx_start_of_cell;
  logic             tx_cell_ready_flag;
  logic             tx_enable_in;
  ucp_pkg::ucp_addr_t tx_slave_select;
  ucp_pkg::ucp_byte_t rx_cell_byte;
  logic             rx_start_of_cell;
  logic             rx_space_ready_flag;
  logic             rx_enable_in;
  ucp_pkg::ucp_addr_t rx_slave_select;
  modport slave
  (
    input  tx_link_clock, rx_link_clock, tx_enable_in, tx_slave_select,
    input  rx_cell_byte, rx_start_of_cell, rx_enable_in, rx_slave_select,
    output tx_cell_byte, tx_start_of_cell, tx_cell_ready_flag,
    output rx_space_ready_flag
  );
  modport master
  (
    output tx_link_clock, rx_link_clock, tx_enable_in, tx_slave_select,
    output rx_cell_byte, rx_start_of_cell, rx_enable_in, rx_slave_select,
    input  tx_cell_byte, tx_start_of_cell, tx_cell_ready_flag,
    input  rx_space_ready_flag
  );
endinterface

// file: rtl/ucp_map.svh
// Constants for the cell port link
`ifndef UCP_MAP_SVH
`define UCP_MAP_SVH
`define UCP_DATA_W      8
`define UCP_ADDR_W      5
`define UCP_CELL_LEN    53
`define UCP_NULL_ADDR   5'h1F
`define UCP_TIEOFF_BYTE 8'h00
`define UCP_CLK_DIV     10
`endif

// file: rtl/ucp_master.sv
// Master end: makes link clocks, polls and moves cells
`timescale 1ns/10ps
`include "ucp_map.svh"
module ucp_master #(
  parameter int CELL_LEN = `UCP_CELL_LEN,
  parameter int CLK_DIV  = `UCP_CLK_DIV
)(
  ucp_link_if.master  link,
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic [4:0] slave_addr,
  input  wire logic   send_req,
  input  wire logic [7:0] send_seed,
  output logic        send_busy,
  output logic        recv_soc_seen,
  output logic [7:0]  recv_byte
);
  logic [7:0] div_q;
  logic       lclk_q;
  logic       fall;
  logic       tx_en_q;
  logic [4:0] tx_adr_q;
  logic [4:0] rx_adr_q;
  logic       rx_en_q;
  logic       rx_soc_q;
  logic [7:0] rx_byte_q;
  logic [5:0] cnt_q;
  logic       soc_q;
  logic [7:0] rb_q;
  ucp_pkg::ucp_xfer_e st_q;
  assign fall = lclk_q && (div_q == 8'(CLK_DIV / 2 - 1));
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      div_q  <= 8'h00;
      lclk_q <= 1'b0;
    end
    else if (div_q == 8'(CLK_DIV / 2 - 1))
    begin
      div_q  <= 8'h00;
      lclk_q <= ~lclk_q;
    end
    else div_q <= 8'(div_q + 8'h01);
  assign link.tx_link_clock = lclk_q; // [RULE3]
  assign link.rx_link_clock = lclk_q;
  // Link outputs change at falling edge; slave samples at rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_en_q <= 1'b0; tx_adr_q <= `UCP_NULL_ADDR;
      rx_en_q <= 1'b0; rx_adr_q <= `UCP_NULL_ADDR;
      rx_soc_q <= 1'b0; rx_byte_q <= 8'h00;
      cnt_q <= 6'h00; st_q <= ucp_pkg::UCP_IDLE;
      soc_q <= 1'b0; rb_q <= 8'h00;
    end
    else if (fall)
    begin
      tx_adr_q <= slave_addr; // [RULE7]
      rx_adr_q <= slave_addr;
      // Enable held once a cell was offered, so whole cells drain
      tx_en_q  <= link.tx_cell_ready_flag | tx_en_q;
      soc_q    <= link.tx_start_of_cell;
      rb_q     <= link.tx_cell_byte;
      unique case (st_q)
        ucp_pkg::UCP_IDLE:
          if (send_req && link.rx_space_ready_flag)
            st_q <= ucp_pkg::UCP_ARM;
        ucp_pkg::UCP_ARM:
        begin
          rx_en_q   <= 1'b1; // [RULE5]
          rx_soc_q  <= 1'b1; // [RULE6]
          rx_byte_q <= send_seed;
          cnt_q     <= 6'h01;
          st_q      <= ucp_pkg::UCP_XFER;
        end
        ucp_pkg::UCP_XFER:
        begin
          rx_soc_q <= 1'b0;
          if (cnt_q == 6'(CELL_LEN))
          begin
            rx_en_q <= 1'b0;
            st_q    <= ucp_pkg::UCP_IDLE;
          end
          else
          begin
            rx_byte_q <= 8'(send_seed + 8'(cnt_q));
            cnt_q     <= 6'(cnt_q + 6'h01);
          end
        end
      endcase
    end
  end
  assign link.tx_enable_in     = tx_en_q; // [RULE11]
  assign link.tx_slave_select  = tx_adr_q;
  assign link.rx_enable_in     = rx_en_q;
  assign link.rx_start_of_cell = rx_soc_q;
  assign link.rx_cell_byte     = rx_byte_q;
  assign link.rx_slave_select  = rx_adr_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      send_busy <= 1'b0; recv_soc_seen <= 1'b0; recv_byte <= 8'h00;
    end
    else
    begin
      send_busy     <= (st_q != ucp_pkg::UCP_IDLE);
      recv_soc_seen <= soc_q;
      recv_byte     <= rb_q;
    end
endmodule

// file: rtl/ucp_pkg.sv
// Types shared by both ends of the cell port link
package ucp_pkg;
  typedef logic [7:0] ucp_byte_t;
  typedef logic [4:0] ucp_addr_t;
  typedef enum logic [1:0]
  {
    UCP_IDLE = 2'b00,
    UCP_ARM  = 2'b01,
    UCP_XFER = 2'b10
  } ucp_xfer_e;
endpackage

// file: rtl/ucp_slave.sv
// Slave end of the cell port link, clocked by the link clocks
// Notes on behaviour
// RULE1: Send cell bytes on tx clock rising edge
// RULE2: Strap low ties off transmit outputs
// RULE3: Master sources receive clock; sample on it
// RULE4: Receive flag high when a cell fits
// RULE5: Sample receive data after enable asserted
// RULE6: Start-of-cell marks first receive byte
// RULE7: Respond on receive only when selected
// RULE8: Upper address pins shared with serial port
// RULE9: Lowest two address pins tied off disabled
// RULE10: Capture receive bytes on rx clock edge
// RULE11: Transmit first byte cycle after enable
// RULE12: Transmit flag high when full cell ready
// RULE13: Ignore sides whose address mismatches
`timescale 1ns/10ps
`include "ucp_map.svh"
module ucp_slave #(
  parameter int CELL_LEN = `UCP_CELL_LEN
)(
  ucp_link_if.slave   link,
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   cell_port_enable_strap,
  input  wire logic [4:0] own_addr,
  input  wire logic   user_tx_toggle,
  input  wire logic [7:0] user_tx_seed,
  output logic        user_rx_toggle,
  output logic [7:0]  user_rx_last,
  output logic        serial_mode
);
  logic [1:0] en_tx_s;
  logic [1:0] en_rx_s;
  logic [2:0] txt_s;
  logic       tx_have_q;
  logic       tx_rdy_q;
  logic [1:0] en_clk_s;
  logic [7:0] seed_q;
  logic [7:0] tx_byte_q;
  logic       tx_soc_q;
  logic [5:0] tx_cnt_q;
  logic       tx_sel_q;
  logic       tx_act_q;
  logic [5:0] rx_cnt_q;
  logic       rx_act_q;
  logic       rx_sel_q;
  logic       rx_space_q;
  logic       rx_tog_q;
  logic [7:0] rx_last_q;
  logic [2:0] rxt_s;
  logic [4:0] rx_addr;
  logic       tx_en;
  logic       rx_en;
  assign tx_en = en_tx_s[1];
  assign rx_en = en_rx_s[1];
  // Disabled pins read as zero toward the core
  assign rx_addr = rx_en ? link.rx_slave_select : 5'h00; // [RULE8] [RULE9]
  always_ff @(posedge link.tx_link_clock or posedge rst)
    if (rst) en_tx_s <= 2'h0;
    else en_tx_s <= {en_tx_s[0], cell_port_enable_strap};
  always_ff @(posedge link.rx_link_clock or posedge rst)
    if (rst) en_rx_s <= 2'h0;
    else en_rx_s <= {en_rx_s[0], cell_port_enable_strap};
  always_ff @(posedge link.tx_link_clock or posedge rst)
    if (rst) txt_s <= 3'h0;
    else txt_s <= {txt_s[1:0], user_tx_toggle};
  // Transmit side: one cell made ready per user toggle
  always_ff @(posedge link.tx_link_clock or posedge rst)
  begin
    if (rst)
    begin
      tx_have_q <= 1'b0;
      tx_rdy_q  <= 1'b0;
      seed_q    <= 8'h00;
      tx_byte_q <= `UCP_TIEOFF_BYTE;
      tx_soc_q  <= 1'b0;
      tx_cnt_q  <= 6'h00;
      tx_sel_q  <= 1'b0;
      tx_act_q  <= 1'b0;
    end
    else if (!tx_en)
    begin
      tx_have_q <= 1'b0;
      tx_rdy_q  <= 1'b0; // [RULE2]
      tx_byte_q <= `UCP_TIEOFF_BYTE; // [RULE2]
      tx_soc_q  <= 1'b0;
      tx_act_q  <= 1'b0;
      tx_sel_q  <= 1'b0;
    end
    else
    begin
      tx_sel_q <= (link.tx_slave_select == own_addr); // [RULE13]
      if (txt_s[2] ^ txt_s[1])
      begin
        tx_have_q <= 1'b1;
        seed_q    <= user_tx_seed;
      end
      tx_soc_q <= 1'b0;
      // Ready flag is registered so the pin comes from a flip-flop
      tx_rdy_q <= tx_have_q & ~tx_act_q; // [RULE12]
      if (!tx_act_q && tx_rdy_q && tx_sel_q && link.tx_enable_in)
      begin
        tx_rdy_q  <= 1'b0; // [RULE12]
        tx_act_q  <= 1'b1; // [RULE11]
        tx_soc_q  <= 1'b1;
        tx_byte_q <= seed_q; // [RULE1]
        tx_cnt_q  <= 6'h01;
      end
      else if (tx_act_q && link.tx_enable_in)
      begin
        if (tx_cnt_q == 6'(CELL_LEN))
        begin
          tx_act_q  <= 1'b0;
          tx_have_q <= 1'b0;
          tx_rdy_q  <= 1'b0;
        end
        else
        begin
          tx_byte_q <= 8'(seed_q + 8'(tx_cnt_q)); // [RULE1]
          tx_cnt_q  <= 6'(tx_cnt_q + 6'h01);
        end
      end
    end
  end
  assign link.tx_cell_byte       = tx_byte_q;
  assign link.tx_start_of_cell   = tx_soc_q;
  assign link.tx_cell_ready_flag = tx_rdy_q; // [RULE12]
  // Strap is a pin: two flops before the core clock reads it
  always_ff @(posedge clk or posedge rst)
    if (rst) en_clk_s <= 2'h0;
    else en_clk_s <= {en_clk_s[0], cell_port_enable_strap};
  always_ff @(posedge clk or posedge rst)
    if (rst) rxt_s <= 3'h0;
    else rxt_s <= {rxt_s[1:0], rx_tog_q};
  // Receive side: capture one cell, then hand over by toggle
  always_ff @(posedge link.rx_link_clock or posedge rst) // [RULE3]
  begin
    if (rst)
    begin
      rx_cnt_q   <= 6'h00;
      rx_act_q   <= 1'b0;
      rx_sel_q   <= 1'b0;
      rx_space_q <= 1'b0;
      rx_tog_q   <= 1'b0;
      rx_last_q  <= 8'h00;
    end
    else if (!rx_en)
    begin
      rx_act_q   <= 1'b0;
      rx_sel_q   <= 1'b0;
      rx_space_q <= 1'b0;
    end
    else
    begin
      rx_sel_q   <= (rx_addr == own_addr); // [RULE7] [RULE13]
      rx_space_q <= ~rx_act_q; // [RULE4]
      if (rx_sel_q && link.rx_enable_in && link.rx_start_of_cell) // [RULE5]
      begin
        rx_act_q  <= 1'b1; // [RULE6]
        rx_cnt_q  <= 6'h01;
        rx_last_q <= link.rx_cell_byte; // [RULE10]
      end
      else if (rx_act_q && link.rx_enable_in)
      begin
        rx_last_q <= link.rx_cell_byte; // [RULE10]
        rx_cnt_q  <= 6'(rx_cnt_q + 6'h01);
        if (rx_cnt_q == 6'(CELL_LEN - 1))
        begin
          rx_act_q <= 1'b0;
          rx_tog_q <= ~rx_tog_q;
        end
      end
    end
  end
  assign link.rx_space_ready_flag = rx_space_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      user_rx_toggle <= 1'b0;
      user_rx_last   <= 8'h00;
      serial_mode    <= 1'b1;
    end
    else
    begin
      user_rx_toggle <= rxt_s[2];
      if (rxt_s[2] ^ rxt_s[1])
        user_rx_last <= rx_last_q;
      serial_mode <= ~en_clk_s[1]; // [RULE8]
    end
  end
endmodule

// file: sim/ucp_link_asserts.sv
// Link checker beside the interface joining both ends
`timescale 1ns/10ps
module ucp_link_asserts (
  input wire logic               rst,
  input wire logic               cell_port_enable_strap,
  input wire logic               tx_link_clock,
  input wire logic               rx_link_clock,
  input wire ucp_pkg::ucp_byte_t tx_cell_byte,
  input wire logic               tx_start_of_cell,
  input wire logic               tx_cell_ready_flag,
  input wire logic               tx_enable_in,
  input wire logic               rx_start_of_cell,
  input wire logic               rx_space_ready_flag,
  input wire logic               rx_enable_in
);
  wire s = cell_port_enable_strap;
  a_tx_tieoff: assert property (
    @(posedge tx_link_clock) disable iff (rst) !s && !$past(s, 3)
    |-> tx_cell_byte == 8'h00 && !tx_start_of_cell && !tx_cell_ready_flag)
    else $error("tx pins live while off");
  a_rx_flag_off: assert property (
    @(posedge rx_link_clock) disable iff (rst) !s && !$past(s, 3)
    |-> !rx_space_ready_flag) else $error("rx flag while off");
  a_soc_after_en: assert property (
    @(posedge tx_link_clock) disable iff (rst)
    tx_start_of_cell |-> $past(tx_enable_in)) else $error("soc, no enable");
  a_soc_one_beat: assert property (
    @(posedge tx_link_clock) disable iff (rst)
    tx_start_of_cell |=> !tx_start_of_cell) else $error("soc too long");
  a_soc_ready: assert property (
    @(posedge tx_link_clock) disable iff (rst)
    tx_start_of_cell |-> $past(tx_cell_ready_flag)) else $error("soc, no cell");
  a_soc_strap: assert property (
    @(posedge tx_link_clock) disable iff (rst)
    tx_start_of_cell |-> s) else $error("soc while off");
  a_tx_byte_hold: assert property (
    @(posedge tx_link_clock) disable iff (rst)
    s && $past(s) && !$past(tx_enable_in) |-> $stable(tx_cell_byte))
    else $error("tx byte moved without enable");
  a_rx_soc_en: assert property (
    @(posedge rx_link_clock) disable iff (rst)
    rx_start_of_cell |-> rx_enable_in) else $error("rx soc, no enable");
endmodule

// file: sim/utopia_slave_cell_port_test.sv
// Self-checking bench: master and slave ends joined by the link
`timescale 1ns/10ps
module utopia_slave_cell_port_test;
  localparam int CL = 8;
  logic       clk, rst, strap, ttog, req, hold;
  logic [4:0] own, sel;
  logic [7:0] tseed, sseed, exp;
  logic       rtog, smode, busy, soc;
  logic [7:0] rlast, rbyte;
  int         seed = 32'hE33A808E;
  int         err_total, check_count, n;
  ucp_link_if lk ();
  ucp_slave #(.CELL_LEN(CL)) ucp_slave_i (
    .link(lk.slave), .clk(clk), .rst(rst), .cell_port_enable_strap(strap),
    .own_addr(own), .user_tx_toggle(ttog), .user_tx_seed(tseed),
    .user_rx_toggle(rtog), .user_rx_last(rlast), .serial_mode(smode));
  ucp_master #(.CELL_LEN(CL)) ucp_master_i (
    .link(lk.master), .clk(clk), .rst(rst), .slave_addr(sel),
    .send_req(req), .send_seed(sseed), .send_busy(busy),
    .recv_soc_seen(soc), .recv_byte(rbyte));
  ucp_link_asserts chk_i (
    .rst(rst), .cell_port_enable_strap(strap),
    .tx_link_clock(lk.tx_link_clock), .rx_link_clock(lk.rx_link_clock),
    .tx_cell_byte(lk.tx_cell_byte), .tx_start_of_cell(lk.tx_start_of_cell),
    .tx_cell_ready_flag(lk.tx_cell_ready_flag),
    .tx_enable_in(lk.tx_enable_in), .rx_start_of_cell(lk.rx_start_of_cell),
    .rx_space_ready_flag(lk.rx_space_ready_flag),
    .rx_enable_in(lk.rx_enable_in));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  function automatic logic [7:0] lastb(input logic [7:0] first);
    return first + 8'(CL - 1);
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    close_out;
  end
  task automatic tx_cell(input logic [7:0] first);
    tseed = first;
    ttog = ~ttog;
    for (n = 0; n < 3000 && rbyte !== lastb(first); n++) step(1);
  endtask
  task automatic rx_cell(input logic [7:0] first);
    hold = rtog;
    sseed = first;
    req = 1'b1;
    for (n = 0; n < 3000 && busy !== 1'b1; n++) step(1);
    req = 1'b0;
    for (n = 0; n < 3000 && rtog === hold; n++) step(1);
    step(20);
  endtask
  initial
  begin
    rst = 1'b1;
    strap = 1'b0;
    ttog = 1'b0;
    req = 1'b0;
    own = 5'h03;
    sel = 5'h03;
    tseed = 8'h00;
    sseed = 8'h00;
    step(10);
    rst = 1'b0;
    step(200);
    check(8'(smode), 8'h01);
    check(lk.tx_cell_byte, 8'h00);
    check(8'(lk.rx_space_ready_flag), 8'h00);
    own = 5'($random(seed)) & 5'h0F;
    sel = own;
    strap = 1'b1;
    step(200);
    check(8'(smode), 8'h00);
    check(8'(lk.rx_space_ready_flag), 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      exp = (i == 0) ? 8'hFC : 8'($random(seed));
      tx_cell(exp);
      check(rbyte, lastb(exp));
      exp = (i == 0) ? 8'hFE : 8'($random(seed));
      rx_cell(exp);
      check(rlast, lastb(exp));
    end
    // Other slave selected: nothing may move
    sel = own ^ 5'h10;
    exp = rbyte;
    hold = rtog;
    tseed = 8'h55;
    ttog = ~ttog;
    req = 1'b1;
    step(400);
    check(rbyte, exp);
    check(8'(rtog), 8'(hold));
    req = 1'b0;
    strap = 1'b0;
    step(200);
    check(lk.tx_cell_byte, 8'h00);
    check(8'(lk.tx_cell_ready_flag), 8'h00);
    check(8'(lk.rx_space_ready_flag), 8'h00);
    check(8'(smode), 8'h01);
    close_out;
  end
endmodule
